// File: pecd_asserts.sv
/* checker of the port edge change detector, bound to pecd_top
   assumes one clock domain with clk_en held high */
`timescale 1ns/1ps
`default_nettype none
module pecd_asserts
#(
   parameter int ADDR_W   = 12,
   parameter int NUM_PINS = 4
)
(
   // clock and reset
   input wire logic                clk,
   input wire logic                sys_rst,
   input wire logic                clk_en,
   // apb
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [ADDR_W-1:0]   paddr,
   input wire logic [31:0]         pwdata,
   input wire logic [3:0]          pstrb,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   // pins and events
   input wire logic [NUM_PINS-1:0] port_pin,
   input wire logic                change_summary_flag,
   input wire logic                irq
);
   // ******
   // shadow enables and age of the last armed edge
   // ******
   logic [NUM_PINS-1:0] prev_pin;
   logic [NUM_PINS-1:0] rise_en;
   logic [NUM_PINS-1:0] fall_en;
   logic [3:0]          age;
   logic                clr_d;
   wire wr_ok = pready && pwrite && pstrb[0];
   wire rise_hit = |(port_pin & ~prev_pin & rise_en);
   wire fall_hit = |(~port_pin & prev_pin & fall_en);
   wire clr_wr = wr_ok && paddr == 'hC && pwdata[0];
   // a flag write also restarts the age, as software may set flags
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         prev_pin <= '0;
         rise_en <= '0;
         fall_en <= '0;
         age <= 4'hF;
         clr_d <= 1'b0;
      end
      else
      begin
         prev_pin <= port_pin;
         clr_d <= clr_wr;
         if (wr_ok && paddr == 'h0)
            rise_en <= pwdata[7:4];
         if (wr_ok && paddr == 'h4)
            fall_en <= pwdata[7:4];
         if (rise_hit || fall_hit || (wr_ok && paddr == 'h8))
            age <= 4'h0;
         else if (age != 4'hF)
            age <= age + 4'h1;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst || !clk_en);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_read_low;
      pready && !pwrite && !pslverr && paddr < 'hC;
   endsequence
   a_ready_wait: assert property (s_setup |=> ##1 pready)
      else $error("no answer one wait cycle after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held two cycles");
   a_rise_sets: assert property (rise_hit |-> ##[2:8] change_summary_flag)
      else $error("armed rising edge not flagged");
   a_fall_sets: assert property (fall_hit |-> ##[2:8] change_summary_flag)
      else $error("armed falling edge not flagged");
   a_no_spurious: assert property ($rose(change_summary_flag) |-> age < 4'hA)
      else $error("summary set without armed edge");
   a_hold_flag: assert property (change_summary_flag && !clr_d |=> change_summary_flag)
      else $error("summary dropped without clear");
   a_reset_quiet: assert property ($fell(sys_rst) |-> !change_summary_flag && !irq)
      else $error("events not clear after reset");
   a_low_bits: assert property (s_read_low |-> prdata[3:0] == '0 && prdata[31:8] == '0)
      else $error("unused read bits not zero");
endmodule : pecd_asserts
bind pecd_top pecd_asserts #(.ADDR_W(ADDR_W), .NUM_PINS(NUM_PINS)) i_pecd_asserts (.*);
`default_nettype wire

// File: pecd_cfg.svh
/*
 * Constants of the port edge change detector: register byte offsets,
 * field positions and reset values.
 * Assumes it is included by its bare name, after any package imports.
 */
`ifndef PECD_CFG_SVH
`define PECD_CFG_SVH

// ****************************************************************
// register byte offsets on the apb
// ****************************************************************
`define PECD_OFS_RISE      12'h000
`define PECD_OFS_FALL      12'h004
`define PECD_OFS_FLAGS     12'h008
`define PECD_OFS_STATUS    12'h00C
`define PECD_OFS_MASK      12'h010

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define PECD_PIN_LSB       4
`define PECD_PIN_MSB       7
`define PECD_REG_RESET     8'h00
`define PECD_STAT_RESET    2'h0
`define PECD_STAT_SUMMARY  0
`define PECD_STAT_OVERRUN  1
`define PECD_STAT_W        2

`endif

// File: pecd_pin_model.sv
/* behavioural source of the four watched port pins
   assumes target and lag change just after a clock edge */
`timescale 1ns/1ps
`default_nettype none
module pecd_pin_model
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // wanted level and delay
   input  wire logic [3:0] target,
   input  wire logic [1:0] lag,
   // pins
   output logic      [3:0] port_pin
);
   logic [15:0] pipe;
   // a slow source is a lag of up to three extra cycles
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         pipe <= '0;
      else
         pipe <= {pipe[11:0], target};
   end
   assign port_pin = pipe[4*lag +: 4];
endmodule : pecd_pin_model
`default_nettype wire

// File: pecd_pin_sync.sv
/*
 * Pin synchroniser and edge detector for the watched port pins.
 * Assumes pins are asynchronous to clk; edges are one-cycle pulses.
 */
`timescale 1ns/1ps
`default_nettype none

module pecd_pin_sync
#(
   parameter int NUM_PINS = 4
)
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire logic                  clk_en,
   // pins
   input  wire logic [NUM_PINS-1:0]   port_pin,
   // edges
   output var  pecd_pkg::pecd_pin_evt_t evt
);
   import pecd_pkg::*;

   logic [NUM_PINS-1:0] meta;
   logic [NUM_PINS-1:0] stage2;
   logic [NUM_PINS-1:0] stage3;
   logic [NUM_PINS-1:0] level;
   logic                primed;

   // ****************************************************************
   // three-stage sampling, first stage feeds only the second
   // ****************************************************************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         meta   <= '0;
         stage2 <= '0;
         stage3 <= '0;
         primed <= 1'b0;
      end
      else if (clk_en)
      begin
         meta   <= port_pin;
         stage2 <= meta;
         stage3 <= stage2;
         primed <= 1'b1;
      end
   end

   // ****************************************************************
   // filtered level and edges
   // ****************************************************************
   genvar i;
   generate
      for (i = 0; i < NUM_PINS; i++)
      begin : g_pin
         wire agree = (stage2[i] == stage3[i]);
         // until primed the edges are masked, but the stages and level reset low, so a pin
         // high at reset release still shows as a rising edge once it reaches stage3
         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
               level[i] <= 1'b0;
            else if (clk_en && agree)
               level[i] <= stage3[i];
         end
         assign evt.rise[i] = clk_en & primed & agree & stage3[i] & ~level[i];
         assign evt.fall[i] = clk_en & primed & agree & ~stage3[i] & level[i];
      end
   endgenerate

endmodule : pecd_pin_sync

`default_nettype wire

// File: pecd_pkg.sv
/*
 * Types shared by the port edge change detector modules.
 * Assumes nothing of its surroundings.
 */
package pecd_pkg;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed
   {
      logic [3:0] rise;
      logic [3:0] fall;
   } pecd_pin_evt_t;

   typedef struct packed
   {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } pecd_apb_req_t;

   typedef struct packed
   {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } pecd_apb_rsp_t;

   // ****************************************************************
   // register selection
   // ****************************************************************
   typedef enum logic [2:0]
   {
      PECD_SEL_RISE   = 3'b000,
      PECD_SEL_FALL   = 3'b001,
      PECD_SEL_FLAGS  = 3'b010,
      PECD_SEL_STATUS = 3'b011,
      PECD_SEL_MASK   = 3'b100,
      PECD_SEL_NONE   = 3'b101
   } pecd_sel_t;

endpackage : pecd_pkg

// File: pecd_sticky.sv
/*
 * Sticky flag bank: hardware sets, software writes or clears.
 * Assumes set and wr are single-cycle qualified by the caller.
 */
`timescale 1ns/1ps
`default_nettype none

module pecd_sticky
#(
   parameter int         W   = 4,
   parameter bit         W1C = 1'b0,
   parameter logic [7:0] RST = 8'h00
)
(
   // clock and reset
   input  wire logic          clk,
   input  wire logic          sys_rst,
   input  wire logic          clk_en,
   // hardware set and software write
   input  wire logic [W-1:0]  set,
   input  wire logic          wr,
   input  wire logic [W-1:0]  wdata,
   // state
   output logic      [W-1:0]  q
);
   import pecd_pkg::*;

   // a hardware set in the same cycle as a clear always wins
   wire [W-1:0] sw_val = W1C ? (q & ~wdata) : wdata;
   wire [W-1:0] next_q = set | (wr ? sw_val : q);

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         q <= RST[W-1:0];
      else if (clk_en)
         q <= next_q;
   end

endmodule : pecd_sticky

`default_nettype wire

// File: pecd_top.sv
/*
 * Port edge change detector: edge enables, per-pin change flags,
 * summary flag and interrupt, reached over an apb slave.
 * Assumes a single clock, pins asynchronous to it, apb master on clk.
 */
`timescale 1ns/1ps
`default_nettype none

`include "pecd_cfg.svh"

// Behaviour
// - armed rising enable: low-to-high on pin 7..4 sets pin flag and summary
// - armed falling enable: high-to-low on pin 7..4 sets pin flag and summary
// - both enables clear: no detection, pin flag never set by pin activity
// - flag set only by enabled rise with rising edge, or enabled fall
// - flags stay set until software writes zero; also software writable
// - enables and flags reset to zero on any reset; bits 3..0 of the enable and flag registers read zero
module pecd_top
#(
   parameter int ADDR_W   = 12,
   parameter int NUM_PINS = 4
)
(
   // clock and reset
   input  wire logic               clk,
   input  wire logic               sys_rst,
   input  wire logic               clk_en,
   // apb slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [ADDR_W-1:0]  paddr,
   input  wire logic [31:0]        pwdata,
   input  wire logic [3:0]         pstrb,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // port pins 7..4, bit 0 is pin 4
   input  wire logic [NUM_PINS-1:0] port_pin,
   // events
   output logic                    change_summary_flag,
   output logic                    irq
);
   import pecd_pkg::*;

   // ****************************************************************
   // address decode
   // ****************************************************************
   function automatic pecd_sel_t pecd_decode(input logic [ADDR_W-1:0] a);
      pecd_sel_t s;
      s = PECD_SEL_NONE;
      unique case (a)
         `PECD_OFS_RISE   : s = PECD_SEL_RISE;
         `PECD_OFS_FALL   : s = PECD_SEL_FALL;
         `PECD_OFS_FLAGS  : s = PECD_SEL_FLAGS;
         `PECD_OFS_STATUS : s = PECD_SEL_STATUS;
         `PECD_OFS_MASK   : s = PECD_SEL_MASK;
         default          : s = PECD_SEL_NONE;
      endcase
      return s;
   endfunction : pecd_decode

   pecd_apb_req_t req;
   assign req.psel    = psel;
   assign req.penable = penable;
   assign req.pwrite  = pwrite;
   assign req.paddr   = paddr[11:0];
   assign req.pwdata  = pwdata;
   assign req.pstrb   = pstrb;

   wire pecd_sel_t sel     = pecd_decode(req.paddr);
   wire            access  = req.psel & req.penable;
   // pready is registered: the access phase holds one wait cycle,
   // trading a cycle of latency for a flop-driven answer
   wire            commit  = access & pready;
   wire            wr_lane = commit & req.pwrite & req.pstrb[0] & ~pslverr;
   wire            wr_rise  = wr_lane & (sel == PECD_SEL_RISE);
   wire            wr_fall  = wr_lane & (sel == PECD_SEL_FALL);
   wire            wr_flags = wr_lane & (sel == PECD_SEL_FLAGS);
   wire            wr_stat  = wr_lane & (sel == PECD_SEL_STATUS);
   wire            wr_mask  = wr_lane & (sel == PECD_SEL_MASK);
   wire [7:0]      wbyte    = req.pwdata[7:0];

   // ****************************************************************
   // edge enable registers
   // ****************************************************************
   localparam logic [7:0] REG_RST = `PECD_REG_RESET;

   logic [NUM_PINS-1:0] rise_edge_enable;
   logic [NUM_PINS-1:0] fall_edge_enable;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rise_edge_enable <= REG_RST[`PECD_PIN_MSB:`PECD_PIN_LSB];
         fall_edge_enable <= REG_RST[`PECD_PIN_MSB:`PECD_PIN_LSB];
      end
      else if (clk_en)
      begin
         if (wr_rise)
            rise_edge_enable <= wbyte[`PECD_PIN_MSB:`PECD_PIN_LSB];
         if (wr_fall)
            fall_edge_enable <= wbyte[`PECD_PIN_MSB:`PECD_PIN_LSB];
      end
   end

   // ****************************************************************
   // pin sampling and edge qualification
   // ****************************************************************
   pecd_pin_evt_t evt;

   pecd_pin_sync #(.NUM_PINS(NUM_PINS)) u_sync
   (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .clk_en   (clk_en),
      .port_pin (port_pin),
      .evt      (evt)
   );

   wire [NUM_PINS-1:0] hit_rise = evt.rise & rise_edge_enable;
   wire [NUM_PINS-1:0] hit_fall = evt.fall & fall_edge_enable;
   // with both enables low neither term can fire for that pin
   wire [NUM_PINS-1:0] pin_hit  = hit_rise | hit_fall;
   wire                any_hit  = |pin_hit;

   // ****************************************************************
   // change flags
   // ****************************************************************
   logic [NUM_PINS-1:0] pin_change_flag;

   pecd_sticky #(.W(NUM_PINS), .W1C(1'b0), .RST(`PECD_REG_RESET)) u_flags
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .set     (pin_hit),
      .wr      (wr_flags),
      .wdata   (wbyte[`PECD_PIN_MSB:`PECD_PIN_LSB]),
      .q       (pin_change_flag)
   );

   // ****************************************************************
   // interrupt status and mask
   // ****************************************************************
   // an overrun marks an edge landing on a pin whose flag is still set
   logic [`PECD_STAT_W-1:0] int_status;
   logic [`PECD_STAT_W-1:0] int_mask;
   wire  [`PECD_STAT_W-1:0] stat_set;

   assign stat_set[`PECD_STAT_SUMMARY] = any_hit;
   assign stat_set[`PECD_STAT_OVERRUN] = |(pin_hit & pin_change_flag);

   pecd_sticky #(.W(`PECD_STAT_W), .W1C(1'b1), .RST(`PECD_REG_RESET)) u_status
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .set     (stat_set),
      .wr      (wr_stat),
      .wdata   (wbyte[`PECD_STAT_W-1:0]),
      .q       (int_status)
   );

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         int_mask <= `PECD_STAT_RESET;
      else if (clk_en && wr_mask)
         int_mask <= wbyte[`PECD_STAT_W-1:0];
   end

   // ****************************************************************
   // read mux
   // ****************************************************************
   wire [7:0] pin_byte_rise  = {rise_edge_enable, 4'h0};
   wire [7:0] pin_byte_fall  = {fall_edge_enable, 4'h0};
   wire [7:0] pin_byte_flags = {pin_change_flag, 4'h0};
   wire [7:0] rd_byte =
      (sel == PECD_SEL_RISE)   ? pin_byte_rise  :
      (sel == PECD_SEL_FALL)   ? pin_byte_fall  :
      (sel == PECD_SEL_FLAGS)  ? pin_byte_flags :
      (sel == PECD_SEL_STATUS) ? {6'h00, int_status} :
      (sel == PECD_SEL_MASK)   ? {6'h00, int_mask} : 8'h00;

   wire next_pready  = access & ~pready;
   wire next_pslverr = access & ~pready & (sel == PECD_SEL_NONE);

   // ****************************************************************
   // registered apb answer and outputs
   // ****************************************************************
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pready              <= 1'b0;
         pslverr             <= 1'b0;
         prdata              <= 32'h00000000;
         change_summary_flag <= 1'b0;
         irq                 <= 1'b0;
      end
      else if (clk_en)
      begin
         pready  <= next_pready;
         pslverr <= next_pslverr;
         if (next_pready && !req.pwrite)
            prdata <= {24'h000000, rd_byte};
         // outputs lag the status bits by one cycle so they come from flops
         change_summary_flag <= int_status[`PECD_STAT_SUMMARY];
         irq                 <= |(int_status & int_mask);
      end
   end

endmodule : pecd_top

`default_nettype wire

// File: port_edge_change_detect_test.sv
/* self-checking bench of the port edge change detector
   assumes the checker binds itself and pins come from the model */
`timescale 1ns/1ps
`default_nettype none
module port_edge_change_detect_test;
   import pecd_pkg::*;
   logic        clk;
   logic        sys_rst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  port_pin;
   logic [3:0]  target;
   logic [1:0]  lag;
   logic        csf;
   logic        irq;
   logic [31:0] rnd;
   int          failures;
   int          comparisons;
   pecd_top i_pecd_top
   (
      .clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_pin(port_pin), .change_summary_flag(csf), .irq(irq)
   );
   pecd_pin_model i_pecd_pin_model
   (
      .clk(clk), .sys_rst(sys_rst), .target(target), .lag(lag), .port_pin(port_pin)
   );
   // ******
   // helpers
   // ******
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic logic [3:0] edges(input logic [3:0] o, n, r, f);
      return (n & ~o & r) | (~n & o & f);
   endfunction : edges
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // entered just after a rising edge; one idle cycle follows
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // pready, prdata and pslverr are read as they stood before this edge
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         failures++;
         stop_test();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, x);
   endtask : rd
   task automatic stop_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      stop_test();
   end
   initial
   begin : main
      logic [3:0]  r;
      logic [3:0]  f;
      logic [3:0]  o;
      logic [3:0]  x;
      logic [3:0]  y;
      logic [31:0] q;
      logic        e;
      int          i;
      {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
      {pstrb, target, lag, rnd} = {4'hF, 4'h0, 2'h0, 32'h40CD3D44};
      {failures, comparisons, o} = '0;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 5; i++)
         rd(12'(4 * i), 32'h0);
      apb(1'b0, 12'h014, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      rnd = lfsr(rnd);
      wr(12'h000, rnd);
      rd(12'h000, rnd & 32'hF0);
      wr(12'h004, ~rnd);
      rd(12'h004, ~rnd & 32'hF0);
      wr(12'h008, 32'hF0);
      rd(12'h008, 32'hF0);
      pstrb <= 4'h0;
      wr(12'h008, 32'h0);
      pstrb <= 4'hF;
      rd(12'h008, 32'hF0);
      wr(12'h008, 32'h0);
      rd(12'h008, 32'h0);
      $display("test registers done");
      // first pass toggles with nothing armed, second with all armed
      for (i = 0; i < 32; i++)
      begin
         rnd = lfsr(rnd);
         r = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : rnd[3:0];
         f = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : rnd[7:4];
         x = (i < 2) ? ~o : rnd[11:8];
         y = edges(o, x, r, f);
         wr(12'h000, {24'h0, r, 4'h0});
         wr(12'h004, {24'h0, f, 4'h0});
         wr(12'h010, {30'h0, rnd[13:12]});
         wr(12'h008, 32'h0);
         wr(12'h00C, 32'h3);
         target <= x;
         lag <= rnd[15:14];
         repeat (14) @(posedge clk);
         rd(12'h008, {24'h0, y, 4'h0});
         chk({31'h0, csf}, {31'h0, |y});
         chk({31'h0, irq}, {31'h0, |y & rnd[12]});
         rd(12'h00C, {31'h0, |y});
         o = x;
      end
      $display("test edges done");
      wr(12'h000, 32'hF0);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(12'h000, 32'h0);
      rd(12'h008, 32'h0);
      $display("test reset done");
      stop_test();
   end
endmodule : port_edge_change_detect_test
`default_nettype wire
